// ===== design/lds_top.sv
// Serial control and status logic of the dual-bank LED sink driver.
// Overview of operation
// - A lack of shift clock edges for the timeout flags a watchdog fault.
// - Data bits one to three form the PWM channel address, bit one as LSB.
// - Bits four to thirteen are bank A level, fourteen to 23 bank B level.
// - Data bit 24 set to one disables the watchdog shutdown of the outputs, zero enables it.
// - Bits 25-28 divisor, 29-32 DAC code A, 33-36 DAC code B.
// - Status bits 1-8 and 9-16 flag open outputs of bank A and bank B.
// - Status bit 17 shows a watchdog timeout and bit 18 overtemperature.
// - Status bits 19-21 carry the revision, 22-36 alternating filler.
// - Strobe low shifts; strobe high, first falling edge latches controls.
// - The next rising edge with strobe high loads the status word.
// - Each output turns off while a free ten-bit count exceeds its level.
// - The address picks one of eight channels in each bank per word.
`timescale 1ns/10ps
module lds_top #(
    parameter int WD_CYCLES = lds_pkg::WD_CYCLES,
    parameter logic [2:0] REVISION = lds_pkg::REV_DEFAULT
) (
    input wire logic clk, // System clock, 125 MHz.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic serial_shift_clock, // Shift clock pin.
    input wire logic serial_data_in, // Serial data pin.
    input wire logic transfer_strobe, // Transfer strobe pin.
    input wire logic [7:0] open_a, // Open-circuit sense, bank A.
    input wire logic [7:0] open_b, // Open-circuit sense, bank B.
    input wire logic over_temp, // Over-temperature sense.
    output logic serial_data_out, // Serial data out pin.
    output logic [7:0] out_on_a, // Output enables, bank A.
    output logic [7:0] out_on_b, // Output enables, bank B.
    output logic [3:0] dac_a, // Coarse DAC code, bank A.
    output logic [3:0] dac_b // Coarse DAC code, bank B.
);
    localparam int W = lds_pkg::WORD_W;
    localparam int LW = lds_pkg::LVL_W;

    // Pin synchronisers, three stages each; stage one feeds only stage two.
    logic [2:0] sck_reg, sck_next, sdi_reg, sdi_next, ld_reg, ld_next;
    logic sck_q_reg, sck_q_next;
    always_comb begin
        sck_next = {sck_reg[1:0], serial_shift_clock};
        sdi_next = {sdi_reg[1:0], serial_data_in};
        ld_next = {ld_reg[1:0], transfer_strobe};
        sck_q_next = sck_reg[1] == sck_reg[2] ? sck_reg[2] : sck_q_reg;
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            sck_reg <= 3'h0;
            sdi_reg <= 3'h0;
            ld_reg <= 3'h0;
            sck_q_reg <= 1'b0;
        end else begin
            sck_reg <= sck_next;
            sdi_reg <= sdi_next;
            ld_reg <= ld_next;
            sck_q_reg <= sck_q_next;
        end
    end

    // Edge detection on the filtered shift clock level.
    logic sck_filt, sck_rise, sck_fall, load_hi, data_bit;
    assign sck_filt = sck_reg[1] == sck_reg[2] ? sck_reg[2] : sck_q_reg;
    assign sck_rise = sck_filt & ~sck_q_reg;
    assign sck_fall = ~sck_filt & sck_q_reg;
    assign load_hi = ld_reg[2];
    assign data_bit = sdi_reg[2];

    // Shift path, latch and status capture.
    logic [W-1:0] shift_reg, shift_next;
    logic latched_reg, latched_next;
    logic status_done_reg, status_done_next;
    logic [2:0] addr_reg, addr_next;
    logic [LW-1:0] lvl_a_reg [lds_pkg::NCH];
    logic [LW-1:0] lvl_a_next [lds_pkg::NCH];
    logic [LW-1:0] lvl_b_reg [lds_pkg::NCH];
    logic [LW-1:0] lvl_b_next [lds_pkg::NCH];
    logic wd_dis_reg, wd_dis_next;
    logic [3:0] div_reg, div_next, dac_a_reg, dac_a_next;
    logic [3:0] dac_b_reg, dac_b_next;
    logic wd_fault_reg;
    logic [W-1:0] status_word;

    // Status bits in table order; status bit one is index zero here.
    logic [W-1:0] status_bits;
    assign status_bits = {lds_pkg::FILL_PATTERN, REVISION, over_temp,
                          wd_fault_reg, open_b, open_a};
    // Status bit one is loaded at the far end so that it leaves first.
    for (genvar s = 0; s < W; s++) begin : g_st
        assign status_word[W-1-s] = status_bits[s];
    end

    // Data bit 36 enters first and moves up, so bit one ends at index zero.
    always_comb begin
        shift_next = shift_reg;
        latched_next = latched_reg;
        status_done_next = status_done_reg;
        addr_next = addr_reg;
        lvl_a_next = lvl_a_reg;
        lvl_b_next = lvl_b_reg;
        wd_dis_next = wd_dis_reg;
        div_next = div_reg;
        dac_a_next = dac_a_reg;
        dac_b_next = dac_b_reg;
        if (!load_hi) begin
            latched_next = 1'b0;
            status_done_next = 1'b0;
            if (sck_rise) begin
                shift_next = {shift_reg[W-2:0], data_bit};
            end
        end else if (sck_fall && !latched_reg) begin
            latched_next = 1'b1;
            addr_next = shift_reg[lds_pkg::ADDR_LSB +: 3];
            lvl_a_next[shift_reg[lds_pkg::ADDR_LSB +: 3]] =
                shift_reg[lds_pkg::LVL_A_LSB +: LW];
            lvl_b_next[shift_reg[lds_pkg::ADDR_LSB +: 3]] =
                shift_reg[lds_pkg::LVL_B_LSB +: LW];
            wd_dis_next = shift_reg[lds_pkg::WD_DIS_POS];
            div_next = shift_reg[lds_pkg::DIV_LSB +: 4];
            dac_a_next = shift_reg[lds_pkg::DAC_A_LSB +: 4];
            dac_b_next = shift_reg[lds_pkg::DAC_B_LSB +: 4];
        end else if (sck_rise && latched_reg && !status_done_reg) begin
            status_done_next = 1'b1;
            shift_next = status_word;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            shift_reg <= '0;
            latched_reg <= 1'b0;
            status_done_reg <= 1'b0;
            addr_reg <= 3'h0;
            for (int i = 0; i < lds_pkg::NCH; i++) begin
                lvl_a_reg[i] <= '0;
                lvl_b_reg[i] <= '0;
            end
            wd_dis_reg <= 1'b0;
            div_reg <= 4'h0;
            dac_a_reg <= 4'h0;
            dac_b_reg <= 4'h0;
        end else begin
            shift_reg <= shift_next;
            latched_reg <= latched_next;
            status_done_reg <= status_done_next;
            addr_reg <= addr_next;
            lvl_a_reg <= lvl_a_next;
            lvl_b_reg <= lvl_b_next;
            wd_dis_reg <= wd_dis_next;
            div_reg <= div_next;
            dac_a_reg <= dac_a_next;
            dac_b_reg <= dac_b_next;
        end
    end

    // Watchdog: counts system cycles since the last shift clock edge.
    // The least timeout is used so the fault is never late.
    logic [31:0] wd_cnt_reg, wd_cnt_next;
    logic wd_fault_next;
    always_comb begin
        wd_cnt_next = wd_cnt_reg;
        wd_fault_next = wd_fault_reg;
        if (sck_rise || sck_fall) begin
            wd_cnt_next = 32'h0;
            wd_fault_next = 1'b0;
        end else if (wd_cnt_reg >= 32'(WD_CYCLES - 1)) begin
            wd_fault_next = 1'b1;
        end else begin
            wd_cnt_next = wd_cnt_reg + 32'h1;
        end
    end

    // PWM prescaler and free-running ten-bit count; divisor code n gives /n+1.
    logic [3:0] pre_reg, pre_next;
    logic [LW-1:0] pwm_cnt_reg, pwm_cnt_next;
    always_comb begin
        pre_next = pre_reg;
        pwm_cnt_next = pwm_cnt_reg;
        if (sck_rise) begin
            if (pre_reg >= div_reg) begin
                pre_next = 4'h0;
                pwm_cnt_next = pwm_cnt_reg + 10'h001;
            end else begin
                pre_next = pre_reg + 4'h1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            wd_cnt_reg <= 32'h0;
            wd_fault_reg <= 1'b0;
            pre_reg <= 4'h0;
            pwm_cnt_reg <= '0;
        end else begin
            wd_cnt_reg <= wd_cnt_next;
            wd_fault_reg <= wd_fault_next;
            pre_reg <= pre_next;
            pwm_cnt_reg <= pwm_cnt_next;
        end
    end

    // Output compare per channel; registered so outputs come from flops.
    logic kill;
    assign kill = wd_fault_reg & ~wd_dis_reg;
    logic [7:0] on_a_next, on_b_next;
    for (genvar g = 0; g < lds_pkg::NCH; g++) begin : g_ch
        assign on_a_next[g] = ~kill & ~(pwm_cnt_reg > lvl_a_reg[g]);
        assign on_b_next[g] = ~kill & ~(pwm_cnt_reg > lvl_b_reg[g]);
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            out_on_a <= 8'h00;
            out_on_b <= 8'h00;
            serial_data_out <= 1'b0;
            dac_a <= 4'h0;
            dac_b <= 4'h0;
        end else begin
            out_on_a <= on_a_next;
            out_on_b <= on_b_next;
            serial_data_out <= shift_reg[W-1];
            dac_a <= dac_a_reg;
            dac_b <= dac_b_reg;
        end
    end
endmodule : lds_top

// ===== design/lds_pkg.sv
// Constants for the LED driver serial control and status block.
package lds_pkg;
    localparam int WORD_W = 36;
    // Data word field positions, zero based (bit one of the word is index 0).
    localparam int ADDR_LSB = 0;
    localparam int ADDR_W = 3;
    localparam int LVL_A_LSB = 3;
    localparam int LVL_B_LSB = 13;
    localparam int LVL_W = 10;
    localparam int WD_DIS_POS = 23;
    localparam int DIV_LSB = 24;
    localparam int DIV_W = 4;
    localparam int DAC_A_LSB = 28;
    localparam int DAC_B_LSB = 32;
    localparam int DAC_W = 4;
    localparam int NCH = 8;
    // Status word field positions.
    localparam int OPEN_A_LSB = 0;
    localparam int OPEN_B_LSB = 8;
    localparam int WD_STAT_POS = 16;
    localparam int THERM_POS = 17;
    localparam int REV_LSB = 18;
    localparam int REV_W = 3;
    localparam int FILL_LSB = 21;
    localparam int FILL_W = 15;
    // Filler reads 0,1,0,... starting at status bit 22.
    localparam logic [14:0] FILL_PATTERN = 15'h2AAA;
    // Watchdog timeout, least figure, at a 125 MHz system clock.
    localparam int WD_TIMEOUT_US = 25;
    localparam int CLK_MHZ = 125;
    localparam int WD_CYCLES = WD_TIMEOUT_US * CLK_MHZ;
    localparam logic [2:0] REV_DEFAULT = 3'h1; // Arbitrary value.
endpackage : lds_pkg

// ===== tb/lds_ctrl_model.sv
// Controller model that drives the shift chain pins of the device.
`timescale 1ns/10ps
module lds_ctrl_model (
    input wire logic clk, // System clock, paces the pins.
    output logic serial_shift_clock, // Shift clock to the device.
    output logic serial_data_in, // Serial data to the device.
    output logic transfer_strobe // Transfer strobe to the device.
);
    // The shift clock stands still between frames.
    initial begin
        serial_shift_clock = 1'b0;
        serial_data_in = 1'b0;
        transfer_strobe = 1'b0;
    end
    // Hold one shift clock level for n system clocks.
    task automatic tick(input logic v, input int n);
        serial_shift_clock = v;
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Bit 36 goes first, then the latch and status phases under the strobe.
    task automatic send(input logic [35:0] w, input int n);
        for (int i = 35; i >= 0; i--) begin
            serial_data_in = w[i];
            tick(1'b0, n);
            tick(1'b1, n);
        end
        serial_data_in = ~w[0]; // Released line shows no stale bit.
        transfer_strobe = 1'b1;
        tick(1'b1, n);
        tick(1'b0, n);
        tick(1'b1, 10);
        transfer_strobe = 1'b0;
    endtask : send
endmodule : lds_ctrl_model

// ===== tb/lds_top_monitor.sv
// Concurrent checks on the ports of the serial control block.
`timescale 1ns/10ps
module lds_top_monitor #(parameter int WD_CYCLES = 3125) (
    input wire logic clk, // System clock.
    input wire logic reset, // Synchronous reset.
    input wire logic serial_shift_clock, // Shift clock pin.
    input wire logic serial_data_in, // Serial data pin.
    input wire logic transfer_strobe, // Strobe pin.
    input wire logic [7:0] open_a, // Open sense, bank A.
    input wire logic serial_data_out, // Serial out pin.
    input wire logic [7:0] out_on_a, // Enables, bank A.
    input wire logic [7:0] out_on_b, // Enables, bank B.
    input wire logic [3:0] dac_a, // DAC code A.
    input wire logic [3:0] dac_b // DAC code B.
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic sck_q, ld, st;
    logic [1:0] ph_q;
    logic [15:0] idle_q;
    logic [35:0] sh_q, word_q;
    // Latch and status events, decoded from the raw pins.
    assign ld = sck_q && !serial_shift_clock && transfer_strobe && ph_q == 2'h0;
    assign st = !sck_q && serial_shift_clock && transfer_strobe && ph_q == 2'h1;
    // Shadow shift register and latched word; the pins are held for
    // several clocks, so raw sampling sees every edge.
    always_ff @(posedge clk) begin
        sck_q <= serial_shift_clock;
        if (reset || serial_shift_clock != sck_q) idle_q <= 16'h0000;
        else if (idle_q != 16'hFFFF) idle_q <= idle_q + 16'h0001;
        if (!transfer_strobe) ph_q <= 2'h0;
        else if (ld) ph_q <= 2'h1;
        else if (st) ph_q <= 2'h2;
        if (!transfer_strobe && serial_shift_clock && !sck_q)
            sh_q <= {sh_q[34:0], serial_data_in};
        if (reset) word_q <= 36'h0;
        else if (ld) word_q <= sh_q;
    end
    sequence s_lvl_a;
        ld ##1 word_q[12:3] == 10'h3FF;
    endsequence
    sequence s_lvl_b;
        ld ##1 word_q[22:13] == 10'h3FF;
    endsequence
    dac_a_load_a: assert property (ld |=> ##7 dac_a == word_q[31:28])
        else $error("dac_a differs from latched word");
    dac_b_load_a: assert property (ld |=> ##7 dac_b == word_q[35:32])
        else $error("dac_b differs from latched word");
    dac_hold_a: assert property ((!transfer_strobe)[*8] |=>
        $stable(dac_a) && $stable(dac_b)) else $error("dac moved while shifting");
    lvl_a_on_a: assert property (s_lvl_a |-> ##7 out_on_a[word_q[2:0]])
        else $error("full level output off, bank A");
    lvl_b_on_a: assert property (s_lvl_b |-> ##7 out_on_b[word_q[2:0]])
        else $error("full level output off, bank B");
    status_load_a: assert property (st |-> ##8 serial_data_out == open_a[0])
        else $error("status bit one not on serial out");
    sdo_cause_a: assert property ($changed(serial_data_out) |-> idle_q <= 16'h0008)
        else $error("serial out moved without a shift edge");
    wd_off_a: assert property (idle_q > WD_CYCLES + 10 && !word_q[23] |->
        out_on_a == 8'h00 && out_on_b == 8'h00) else $error("watchdog left outputs on");
endmodule : lds_top_monitor
bind lds_top lds_top_monitor #(.WD_CYCLES(WD_CYCLES)) mon (.clk(clk),
    .reset(reset), .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in), .transfer_strobe(transfer_strobe),
    .open_a(open_a), .serial_data_out(serial_data_out), .out_on_a(out_on_a),
    .out_on_b(out_on_b), .dac_a(dac_a), .dac_b(dac_b));

// ===== tb/lds_top_tb.sv
// Self-checking bench for the serial control and status block.
`timescale 1ns/10ps
module lds_top_tb;
    localparam int WD = 50;
    logic clk, reset, sck, sdi, stb, sdo, over_temp;
    logic [7:0] open_a, open_b, on_a, on_b;
    logic [3:0] dac_a, dac_b;
    logic [15:0] rnd;
    logic [35:0] w;
    int bad_count, compares;
    lds_top #(.WD_CYCLES(WD)) dut (.clk(clk), .reset(reset),
        .serial_shift_clock(sck), .serial_data_in(sdi), .transfer_strobe(stb),
        .open_a(open_a), .open_b(open_b), .over_temp(over_temp),
        .serial_data_out(sdo), .out_on_a(on_a), .out_on_b(on_b),
        .dac_a(dac_a), .dac_b(dac_b));
    lds_ctrl_model ctl (.clk(clk), .serial_shift_clock(sck),
        .serial_data_in(sdi), .transfer_strobe(stb));
    // Free-running 125 MHz clock.
    always #4 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [3:0] exp_dac(input logic [35:0] x, input logic b);
        return b ? x[35:32] : x[31:28];
    endfunction : exp_dac
    // Status word in table order; the watchdog is never timed out here.
    function automatic logic [35:0] exp_status(input logic [7:0] oa,
        input logic [7:0] ob, input logic hot);
        return {lds_pkg::FILL_PATTERN, lds_pkg::REV_DEFAULT, hot, 1'b0, ob, oa};
    endfunction : exp_status
    task automatic check(input string what, input logic [9:0] seen,
        input logic [9:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    // Clocks the rest of the status word out and compares every field.
    task automatic read_status(input logic [35:0] exp_st);
        logic [35:0] got;
        got[0] = sdo;
        for (int i = 1; i < 36; i++) begin
            ctl.tick(1'b0, 4);
            ctl.tick(1'b1, 4);
            repeat (2) @(posedge clk);
            #1;
            got[i] = sdo;
        end
        check("status_open", got[9:0], exp_st[9:0]);
        check("status_flags", got[19:10], exp_st[19:10]);
        check("status_rev", got[29:20], exp_st[29:20]);
        check("status_fill", got[35:30], exp_st[35:30]);
    endtask : read_status
    // One full frame at a random pace, with fresh fault senses.
    task automatic xfer(input logic [35:0] x);
        rnd = lfsr(rnd);
        open_a = rnd[7:0];
        open_b = rnd[15:8];
        over_temp = rnd[5];
        ctl.send(x, rnd[0] ? 10 : 4);
        check("dac_a", dac_a, exp_dac(x, 1'b0));
        check("dac_b", dac_b, exp_dac(x, 1'b1));
        check("status_bit1", sdo, open_a[0]);
        read_status(exp_status(open_a, open_b, over_temp));
    endtask : xfer
    // Main sequence: corner words, random words, then the watchdog.
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        open_a = 8'h00;
        open_b = 8'h00;
        over_temp = 1'b0;
        rnd = 16'hE251;
        bad_count = 0;
        compares = 0;
        repeat (10) @(posedge clk);
        #1 reset = 1'b0;
        xfer(36'h0F07FFFF8);
        check("on_a_ch0", on_a, 10'h001);
        xfer(36'hF0F7FFFFF);
        check("on_b_ch7", on_b, 10'h081);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            w[15:0] = rnd;
            rnd = lfsr(rnd);
            w[35:16] = {rnd[3:0], rnd};
            w[23] = 1'b0;
            xfer(w);
        end
        xfer(36'h0F07FFFF8);
        repeat (80) @(posedge clk);
        check("on_a_wd", on_a, 10'h0);
        check("on_b_wd", on_b, 10'h0);
        xfer(36'h0F0FFFFF8);
        repeat (80) @(posedge clk);
        check("on_a_wd_dis", on_a[0], 10'h1);
        stop_test;
    end
    // Hang guard, well beyond the longest expected run.
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        stop_test;
    end
endmodule : lds_top_tb
